// file: pmc_cfg.svh
// Constants for the PLL miscellaneous control register block.
// Assumes inclusion by bare name from the package and design modules.
//
// Behaviour
// - Bit 7 set routes EEPROM status to pin.
// - Bit 7 clear: pin follows six-bit selection.
// - Bit 6 enables crystal maintaining amplifier.
// - Bit 5 enables reference input doubler.
// - Bit 4 set freezes PLL status readback.
// - Bit 3 clear: holdover reads lock pin as high.
// - Bit 3 set: holdover uses lock comparator.
// - Bit 3 set: comparator observable on pins.
// - Bit 1 set: sync pin governs holdover.
// - Bit 0 enables internal holdover function.
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH

// ****************************************
// Register map
// ****************************************
`define PMC_ADDR_W 10
`define PMC_DATA_W 8
`define PMC_OFS_STATUS_CTRL 10'h017
`define PMC_OFS_MISC_CTRL 10'h01D
`define PMC_OFS_PLL_STATUS 10'h01F

// ****************************************
// Misc control fields and reset
// ****************************************
`define PMC_BIT_EEPROM_STATUS 7
`define PMC_BIT_XTAL_AMP 6
`define PMC_BIT_DOUBLER 5
`define PMC_BIT_STATUS_FREEZE 4
`define PMC_BIT_LD_CMP 3
`define PMC_BIT_UNUSED 2
`define PMC_BIT_EXT_HOLD 1
`define PMC_BIT_HOLD_EN 0
`define PMC_MISC_RESET 8'h80
`define PMC_MISC_WMASK 8'hFB

// ****************************************
// Status pin selection
// ****************************************
`define PMC_SEL_W 6
`define PMC_SEL_LD_CMP 6'h3F

`endif

// file: pmc_pkg.sv
// Types shared by the PLL miscellaneous control block.
// Assumes pmc_cfg.svh is on the include path.
`include "pmc_cfg.svh"

package pmc_pkg;

   // Holdover controller states, one-hot
   typedef enum logic [2:0] {
      PMC_HC_TRACK = 3'b001,
      PMC_HC_HOLD = 3'b010,
      PMC_HC_EXT = 3'b100
   } pmc_hold_state_t;

   typedef logic [`PMC_DATA_W-1:0] pmc_byte_t;

endpackage

// file: pmc_hold_if.sv
// Carrier between the register top and the holdover controller.
// Assumes both ends share the block clock.
`timescale 1ns/1ns

interface pmc_hold_if;
   logic hold_en;
   logic ext_mode;
   logic lock_seen;
   logic sync_hold_req;
   logic ref_bad;
   logic holdover;

   modport ctrl (
      output hold_en,
      output ext_mode,
      output lock_seen,
      output sync_hold_req,
      output ref_bad,
      input holdover
   );

   modport hold (
      input hold_en,
      input ext_mode,
      input lock_seen,
      input sync_hold_req,
      input ref_bad,
      output holdover
   );
endinterface

// file: pmc_holdover.sv
// Holdover controller: automatic, pin-driven or off.
// Assumes inputs synchronous to clk, driven by pmc_top.
`timescale 1ns/1ns

module pmc_holdover
   import pmc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Control from the register top
   pmc_hold_if.hold hif
);

   // ****************************************
   // State
   // ****************************************
   pmc_hold_state_t state_q, state_d;
   logic hold_q, hold_d;
   logic locked_q, locked_d;

   always_comb begin
      state_d = state_q;
      hold_d = hold_q;
      locked_d = locked_q;
      case (state_q)
         PMC_HC_TRACK: begin
            hold_d = 1'b0;
            locked_d = hif.lock_seen;
            if (hif.ext_mode) begin
               state_d = PMC_HC_EXT;
            end else if (hif.hold_en && hif.ref_bad && locked_q) begin
               state_d = PMC_HC_HOLD;
               hold_d = 1'b1;
            end
         end
         PMC_HC_HOLD: begin
            hold_d = 1'b1;
            if (hif.ext_mode) begin
               state_d = PMC_HC_EXT;
            end else if (!hif.hold_en || !hif.ref_bad) begin
               state_d = PMC_HC_TRACK;
               hold_d = 1'b0;
            end
         end
         PMC_HC_EXT: begin
            hold_d = hif.sync_hold_req;
            if (!hif.ext_mode) begin
               state_d = PMC_HC_TRACK;
               hold_d = 1'b0;
            end
         end
         default: begin
            state_d = PMC_HC_TRACK;
            hold_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= PMC_HC_TRACK;
         hold_q <= 1'b0;
         locked_q <= 1'b0;
      end else begin
         state_q <= state_d;
         hold_q <= hold_d;
         locked_q <= locked_d;
      end
   end

   assign hif.holdover = hold_q;

endmodule // pmc_holdover

// file: pmc_top.sv
// PLL miscellaneous control register and the logic it steers.
// Assumes a serial port decoder presents parallel register cycles
// synchronous to clk; status control field arrives from its own register.
`timescale 1ns/1ns
`include "pmc_cfg.svh"

module pmc_top
   import pmc_pkg::*;
#(
   parameter int SRC_N = 64
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Register access from the serial control port
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [`PMC_ADDR_W-1:0] reg_addr,
   input wire logic [`PMC_DATA_W-1:0] reg_wdata,
   output logic [`PMC_DATA_W-1:0] reg_rdata_q,
   output logic reg_rd_valid_q,
   // Status pin
   input wire logic eeprom_status,
   input wire logic [`PMC_SEL_W-1:0] status_sel,
   input wire logic [SRC_N-1:0] status_src,
   output logic status_pin_q,
   // Reference input analog controls
   output logic crystal_maintaining_amp_en_q,
   output logic ref_doubler_en_q,
   // PLL status readback
   input wire logic [`PMC_DATA_W-1:0] pll_status_live,
   output logic pll_status_frozen_q,
   // Lock detect comparator
   input wire logic lock_detect_pin,
   output logic ld_cmp_mon_q,
   // Holdover
   input wire logic sync_hold_req,
   input wire logic ref_bad,
   output logic holdover_active_q
);

   // ****************************************
   // Address decode helper
   // ****************************************
   function automatic logic pmc_hit(input logic [`PMC_ADDR_W-1:0] a,
                                    input logic [`PMC_ADDR_W-1:0] ofs);
      pmc_hit = (a == ofs);
   endfunction

   // ****************************************
   // Misc control register
   // ****************************************
   pmc_byte_t misc_q, misc_d;

   always_comb begin
      misc_d = misc_q;
      if (reg_wr_en && pmc_hit(reg_addr, `PMC_OFS_MISC_CTRL)) begin
         // Unused bit is never stored
         misc_d = reg_wdata & `PMC_MISC_WMASK;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         misc_q <= `PMC_MISC_RESET;
      end else begin
         misc_q <= misc_d;
      end
   end

   // ****************************************
   // Field views
   // ****************************************
   logic f_eeprom;
   logic f_xtal;
   logic f_dbl;
   logic f_freeze;
   logic f_ldcmp;
   logic f_ext;
   logic f_hold;

   assign f_eeprom = misc_q[`PMC_BIT_EEPROM_STATUS];
   assign f_xtal = misc_q[`PMC_BIT_XTAL_AMP];
   assign f_dbl = misc_q[`PMC_BIT_DOUBLER];
   assign f_freeze = misc_q[`PMC_BIT_STATUS_FREEZE];
   assign f_ldcmp = misc_q[`PMC_BIT_LD_CMP];
   assign f_ext = misc_q[`PMC_BIT_EXT_HOLD];
   assign f_hold = misc_q[`PMC_BIT_HOLD_EN];

   // ****************************************
   // Lock detect comparator
   // ****************************************
   logic ld_cmp;
   logic lock_seen;

   // Comparator off reads as zero for observation
   assign ld_cmp = f_ldcmp & lock_detect_pin;
   // Holdover sees a true high when comparator is off
   assign lock_seen = f_ldcmp ? lock_detect_pin : 1'b1;

   // ****************************************
   // Status pin source
   // ****************************************
   logic sel_src;
   logic status_d;

   always_comb begin
      if (status_sel == `PMC_SEL_LD_CMP) begin
         sel_src = ld_cmp;
      end else if (int'(status_sel) < SRC_N) begin
         sel_src = status_src[status_sel];
      end else begin
         sel_src = 1'b0;
      end
      status_d = f_eeprom ? eeprom_status : sel_src;
   end

   // ****************************************
   // PLL status readback
   // ****************************************
   pmc_byte_t pll_stat_q, pll_stat_d;

   always_comb begin
      pll_stat_d = pll_stat_q;
      if (!f_freeze) begin
         pll_stat_d = pll_status_live;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pll_stat_q <= '0;
      end else begin
         pll_stat_q <= pll_stat_d;
      end
   end

   // ****************************************
   // Read port
   // ****************************************
   pmc_byte_t rdata_d;
   logic rd_valid_d;

   always_comb begin
      rdata_d = reg_rdata_q;
      rd_valid_d = reg_rd_en;
      if (reg_rd_en) begin
         if (pmc_hit(reg_addr, `PMC_OFS_MISC_CTRL)) begin
            rdata_d = misc_q;
         end else if (pmc_hit(reg_addr, `PMC_OFS_PLL_STATUS)) begin
            rdata_d = pll_stat_q;
         end else begin
            rdata_d = '0;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata_q <= '0;
         reg_rd_valid_q <= 1'b0;
      end else begin
         reg_rdata_q <= rdata_d;
         reg_rd_valid_q <= rd_valid_d;
      end
   end

   // ****************************************
   // Holdover controller
   // ****************************************
   pmc_hold_if hif ();

   assign hif.hold_en = f_hold;
   assign hif.ext_mode = f_ext;
   assign hif.lock_seen = lock_seen;
   assign hif.sync_hold_req = sync_hold_req;
   assign hif.ref_bad = ref_bad;

   pmc_holdover u_hold (
      .clk (clk),
      .rstn (rstn),
      .hif (hif)
   );

   // ****************************************
   // Output registers
   // ****************************************
   logic xtal_d;
   logic dbl_d;
   logic frozen_d;
   logic ldmon_d;
   logic hold_d;

   always_comb begin
      xtal_d = f_xtal;
      dbl_d = f_dbl;
      frozen_d = f_freeze;
      ldmon_d = ld_cmp;
      hold_d = hif.holdover;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         status_pin_q <= 1'b0;
         crystal_maintaining_amp_en_q <= 1'b0;
         ref_doubler_en_q <= 1'b0;
         pll_status_frozen_q <= 1'b0;
         ld_cmp_mon_q <= 1'b0;
         holdover_active_q <= 1'b0;
      end else begin
         status_pin_q <= status_d;
         crystal_maintaining_amp_en_q <= xtal_d;
         ref_doubler_en_q <= dbl_d;
         pll_status_frozen_q <= frozen_d;
         ld_cmp_mon_q <= ldmon_d;
         holdover_active_q <= hold_d;
      end
   end

endmodule // pmc_top

// file: pmc_top_checker.sv
// Concurrent checks on the ports of pmc_top.
// Assumes binding to pmc_top; sees only its ports.
`timescale 1ns/1ns
`include "pmc_cfg.svh"

module pmc_top_checker
   import pmc_pkg::*;
#(
   parameter int SRC_N = 64
)
(
   // Clock, reset and register port
   input wire logic clk,
   input wire logic rstn,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [`PMC_ADDR_W-1:0] reg_addr,
   input wire logic [`PMC_DATA_W-1:0] reg_wdata,
   input wire logic [`PMC_DATA_W-1:0] reg_rdata_q,
   // Pins
   input wire logic eeprom_status,
   input wire logic [`PMC_SEL_W-1:0] status_sel,
   input wire logic [SRC_N-1:0] status_src,
   input wire logic status_pin_q,
   input wire logic crystal_maintaining_amp_en_q,
   input wire logic ref_doubler_en_q,
   input wire logic pll_status_frozen_q,
   input wire logic lock_detect_pin,
   input wire logic ld_cmp_mon_q,
   input wire logic sync_hold_req,
   input wire logic ref_bad,
   input wire logic holdover_active_q
);
   // ***
   // Shadow of the control register
   // ***
   logic [7:0] m_q;
   logic [7:0] m_d;
   wire wr1d = reg_wr_en && reg_addr == 10'h01D;

   always_comb begin
      m_d = m_q;
      if (wr1d) m_d = reg_wdata & 8'hFB;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) m_q <= 8'h80;
      else m_q <= m_d;
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   a_status_eeprom: assert property (m_q[7] |=> status_pin_q == $past(eeprom_status))
      else $error("status pin not eeprom");
   a_status_select: assert property (!m_q[7] && status_sel != 6'h3F |=>
      status_pin_q == $past(status_src[status_sel])) else $error("status pin source");
   a_ld_select: assert property (!m_q[7] && status_sel == 6'h3F |=>
      status_pin_q == $past(m_q[3] && lock_detect_pin)) else $error("status pin lock");
   a_ld_mon_off: assert property (!m_q[3] [*2] |=> !ld_cmp_mon_q)
      else $error("lock monitor on");
   a_xtal_amp: assert property (wr1d |-> ##2 crystal_maintaining_amp_en_q == $past(reg_wdata[6], 2))
      else $error("amp enable");
   a_ref_doubler: assert property (wr1d |-> ##2 ref_doubler_en_q == $past(reg_wdata[5], 2))
      else $error("doubler enable");
   a_status_freeze: assert property (wr1d |-> ##2 pll_status_frozen_q == $past(reg_wdata[4], 2))
      else $error("status freeze");
   a_read_misc: assert property (reg_rd_en && !reg_wr_en && reg_addr == 10'h01D |=>
      reg_rdata_q == $past(m_q)) else $error("misc readback");
   a_hold_ext: assert property (m_q[1] [*3] |=> holdover_active_q == $past(sync_hold_req, 2))
      else $error("external hold");
   a_hold_off: assert property ((!m_q[1] && !(m_q[0] && ref_bad)) [*3] |=> !holdover_active_q)
      else $error("hold not off");
   a_hold_enter: assert property ((m_q[0] && !m_q[1] && !m_q[3] && ref_bad) [*4] |=>
      holdover_active_q) else $error("hold not entered");
endmodule // pmc_top_checker

bind pmc_top pmc_top_checker #(.SRC_N(SRC_N)) chk_u (.*);

// file: testbench.sv
// Self-checking bench for pmc_top.
// Assumes header, package, carrier and design compiled first.
`timescale 1ns/1ns

module testbench;
   import pmc_pkg::*;
   logic clk = 1'b0, rstn = 1'b0, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
   logic eeprom_status = 1'b0, lock_detect_pin = 1'b0, sync_hold_req = 1'b0, ref_bad = 1'b0;
   logic [9:0] reg_addr = 10'h000;
   logic [7:0] reg_wdata = 8'h00, pll_status_live = 8'h00, reg_rdata_q, m, v;
   logic [5:0] status_sel = 6'h00;
   logic [63:0] status_src = 64'h0;
   logic reg_rd_valid_q, status_pin_q, crystal_maintaining_amp_en_q, ref_doubler_en_q;
   logic pll_status_frozen_q, ld_cmp_mon_q, holdover_active_q;
   logic [31:0] r = 32'h829C;
   logic [7:0] exp_q[$];
   int err_total = 0;
   int num_checks = 0;

   pmc_top dut_u (.*);

   always #25 clk = ~clk;

   // ***
   // Helpers
   // ***
   function automatic logic [31:0] nxt(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(string n, logic [63:0] s, logic [63:0] e);
      num_checks++;
      if (s !== e) begin
         err_total++;
         $display("CHECK FAILED %s exp %h got %h", n, e, s);
      end
   endtask

   task automatic conclude;
      if (err_total == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic tick(int n);
      repeat (n) @(posedge clk);
      #5;
   endtask

   // Each access leaves one idle cycle so strobes never toggle twice at once
   task automatic wr(logic [9:0] a, logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr_en = 1'b1;
      tick(1);
      reg_wr_en = 1'b0;
      if (a == 10'h01D) m = d & 8'hFB;
      tick(1);
   endtask

   task automatic rd(logic [9:0] a, logic [7:0] e);
      exp_q.push_back(e);
      reg_addr = a;
      reg_rd_en = 1'b1;
      tick(1);
      reg_rd_en = 1'b0;
      tick(1);
   endtask

   // Every valid pulse must match exactly one pending read
   always @(negedge clk)
      if (reg_rd_valid_q === 1'b1) begin
         check("rdq", exp_q.size() != 0, 1);
         if (exp_q.size() != 0) check("rdata", reg_rdata_q, exp_q.pop_front());
      end

   // ***
   // Scenarios
   // ***
   initial begin
      tick(6);
      rstn = 1'b1;
      m = 8'h80;
      rd(10'h01D, 8'h80);
      check("amp", crystal_maintaining_amp_en_q, 0);
      check("dbl", ref_doubler_en_q, 0);
      for (int i = 0; i < 8; i++) begin
         r = nxt(r);
         eeprom_status = r[0];
         status_sel = r[6:1];
         status_src = {r, ~r};
         tick(1);
         check("pin", status_pin_q, eeprom_status);
      end
      for (int i = 0; i < 6; i++) begin
         r = nxt(r);
         wr(10'h01D, i == 0 ? 8'hFF : r[7:0] | 8'h04);
         check("amp", crystal_maintaining_amp_en_q, m[6]);
         check("dbl", ref_doubler_en_q, m[5]);
         check("frz", pll_status_frozen_q, m[4]);
         rd(10'h01D, m);
      end
      wr(10'h01D, 8'h08);
      for (int i = 0; i < 64; i++) begin
         r = nxt(r);
         status_sel = 6'(i);
         status_src = {r, nxt(r)};
         lock_detect_pin = r[9];
         tick(2);
         check("pin", status_pin_q, i == 63 ? lock_detect_pin : status_src[i]);
         check("ldm", ld_cmp_mon_q, lock_detect_pin);
      end
      wr(10'h01D, 8'h00);
      lock_detect_pin = 1'b1;
      tick(2);
      check("pin", status_pin_q, 0);
      check("ldm", ld_cmp_mon_q, 0);
      v = r[15:8];
      pll_status_live = v;
      tick(2);
      rd(10'h01F, v);
      wr(10'h01D, 8'h10);
      pll_status_live = ~v;
      tick(2);
      rd(10'h01F, v);
      wr(10'h01D, 8'h00);
      tick(1);
      rd(10'h01F, ~v);
      wr(10'h3FF, 8'hFF);
      wr(10'h017, 8'hFF);
      rd(10'h01D, m);
      rd(10'h3FF, 8'h00);
      wr(10'h01D, 8'h02);
      tick(2);
      for (int i = 0; i < 8; i++) begin
         r = nxt(r);
         sync_hold_req = r[0];
         tick(2);
         check("hold", holdover_active_q, sync_hold_req);
      end
      sync_hold_req = 1'b1;
      wr(10'h01D, 8'h01);
      ref_bad = 1'b1;
      tick(4);
      check("hold", holdover_active_q, 1);
      ref_bad = 1'b0;
      tick(4);
      check("hold", holdover_active_q, 0);
      wr(10'h01D, 8'h09);
      lock_detect_pin = 1'b0;
      tick(2);
      ref_bad = 1'b1;
      tick(4);
      check("hold", holdover_active_q, 0);
      ref_bad = 1'b0;
      lock_detect_pin = 1'b1;
      tick(2);
      ref_bad = 1'b1;
      tick(4);
      check("hold", holdover_active_q, 1);
      wr(10'h01D, 8'h08);
      tick(2);
      check("hold", holdover_active_q, 0);
      check("rdq", exp_q.size(), 0);
      conclude;
   end

   initial begin
      repeat (4000) @(posedge clk);
      err_total++;
      conclude;
   end
endmodule // testbench
